// file: common/psrm_params.svh
/*
 * Offsets, field positions, reset values and limits of the pointer and
 * segment register block. Assumes inclusion by bare name from rtl files.
 */
`ifndef PSRM_PARAMS_SVH
`define PSRM_PARAMS_SVH

// Internal RAM window that holds pointer sets and local registers.
`define PSRM_RAM_BASE  16'h0200
`define PSRM_RAM_LAST  16'h09FF
`define PSRM_PTR_LAST  16'h023F
`define PSRM_RAM_IDX_W 11

// Special function register offsets on the register page.
`define PSRM_SFR_SSPL  8'h00
`define PSRM_SFR_SSPH  8'h01
`define PSRM_SFR_LOCAL_BASE_LOW  8'h02
`define PSRM_SFR_LRBH  8'h03
`define PSRM_SFR_STATUS_WORD_LOW  8'h04
`define PSRM_SFR_STATUS_WORD_HIGH  8'h05
`define PSRM_SFR_TSR   8'h06
`define PSRM_SFR_DSR   8'h07
`define PSRM_SFR_MSC   8'h08

// Memory segment control fields.
`define PSRM_DS_EN_BIT 0
`define PSRM_TS_EN_BIT 1
`define PSRM_MSC_MASK  8'h03

// Reset values and the carry bit position.
`define PSRM_PSW_RST   16'h0000
`define PSRM_SSP_RST   16'hFFFF
`define PSRM_LRB_RST   16'h0000
`define PSRM_SEG_RST   4'h0
`define PSRM_CY_BIT    15

`endif

// file: common/psrm_pkg.sv
/*
 * Types shared by the pointer and segment register block.
 * Assumes the decoder drives requests as these packed structs.
 */
package psrm_pkg;

  typedef enum logic [2:0] {
    PSRM_OP_RAM  = 3'b000,
    PSRM_OP_PTR  = 3'b001,
    PSRM_OP_LOCB = 3'b010,
    PSRM_OP_LOCW = 3'b011,
    PSRM_OP_ACC  = 3'b100,
    PSRM_OP_CTRL = 3'b101,
    PSRM_OP_SFR  = 3'b110
  } psrm_op_t;

  typedef enum logic [2:0] {
    PSRM_FL_NONE  = 3'b000,
    PSRM_FL_FJMP  = 3'b001,
    PSRM_FL_FCALL = 3'b010,
    PSRM_FL_VCALL = 3'b011,
    PSRM_FL_FRET  = 3'b100,
    PSRM_FL_IRET  = 3'b101,
    PSRM_FL_IENT  = 3'b110
  } psrm_flow_op_t;

  typedef struct packed {
    logic        valid;
    psrm_op_t    op;
    logic        write;
    logic        word;
    logic [2:0]  sel;
    logic [15:0] addr;
    logic [15:0] wdata;
  } psrm_req_t;

  typedef struct packed {
    psrm_flow_op_t op;
    logic [3:0]    seg;
    logic [15:0]   target;
  } psrm_flow_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  seg;
    logic [15:0] pc;
  } psrm_frame_t;

endpackage

// file: rtl/psrm_ram.sv
/*
 * Internal RAM for 0200H-09FFH, split into even and odd byte banks.
 * Assumes a byte index relative to 0200H; reads are combinational.
 */
`timescale 1ns/100ps
module psrm_ram #(
  parameter int DEPTH = 1024
) (
  input  wire logic        clk_in,
  input  wire logic [10:0] idx_in,
  input  wire logic        word_in,
  input  wire logic        we_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] rdata_out
);
  logic [7:0] even_mem [DEPTH];
  logic [7:0] odd_mem  [DEPTH];
  logic [9:0] row;

  assign row = idx_in[10:1];

  // Low byte at even address, high byte at the next odd one. [RL5]
  always_ff @(posedge clk_in) begin
    if (we_in && (word_in || !idx_in[0])) begin
      even_mem[row] <= wdata_in[7:0];
    end
    if (we_in && word_in) begin
      odd_mem[row] <= wdata_in[15:8];
    end else if (we_in && idx_in[0]) begin
      odd_mem[row] <= wdata_in[7:0];
    end
  end

  // Odd word addresses fall back to the even word below.
  always_comb begin
    if (word_in) begin
      rdata_out = {odd_mem[row], even_mem[row]};
    end else if (idx_in[0]) begin
      rdata_out = {8'h00, odd_mem[row]};
    end else begin
      rdata_out = {8'h00, even_mem[row]};
    end
  end
endmodule

// file: rtl/psrm_seg.sv
/*
 * Code, table and data segment registers plus the program counter.
 * Assumes the decoder gives control-flow events one cycle each.
 */
`timescale 1ns/100ps
`include "psrm_params.svh"
module psrm_seg (
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  input  wire psrm_pkg::psrm_flow_t  flow_in,
  input  wire logic                  pc_inc_in,
  input  wire logic [2:0]            pc_step_in,
  input  wire logic                  expanded_in,
  input  wire logic                  ts_wr_in,
  input  wire logic                  ds_wr_in,
  input  wire logic [3:0]            wr_data_in,
  input  wire logic                  ts_en_in,
  input  wire logic                  ds_en_in,
  output logic      [3:0]            code_segment_out,
  output logic      [15:0]           pc_out,
  output logic      [3:0]            table_seg_out,
  output logic      [3:0]            data_seg_out,
  output psrm_pkg::psrm_frame_t      frame_out
);
  import psrm_pkg::*;

  // Code segment moves only on far flow events, never by register write. [RL9]
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      code_segment_out <= `PSRM_SEG_RST; // [RL11]
    end else begin
      case (flow_in.op)
        PSRM_FL_FJMP, PSRM_FL_FCALL, PSRM_FL_VCALL,
        PSRM_FL_FRET, PSRM_FL_IENT: code_segment_out <= flow_in.seg;
        PSRM_FL_IRET: if (expanded_in) code_segment_out <= flow_in.seg; // [RL12]
        default: code_segment_out <= code_segment_out;
      endcase
    end
  end

  // The counter wraps in 16 bits and leaves the segment alone. [RL10]
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pc_out <= 16'h0000;
    end else if (flow_in.op != PSRM_FL_NONE) begin
      pc_out <= flow_in.target;
    end else if (pc_inc_in) begin
      pc_out <= pc_out + {13'h0000, pc_step_in};
    end
  end

  // Interrupt entry hands the decoder both words to push when expanded. [RL12]
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      frame_out <= '0;
    end else begin
      frame_out.valid <= (flow_in.op == PSRM_FL_IENT) && expanded_in;
      frame_out.seg   <= code_segment_out;
      frame_out.pc    <= pc_out;
    end
  end

  // Locked writes are dropped; software cannot bypass the enable. [RL13] [RL23]
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      table_seg_out <= `PSRM_SEG_RST; // [RL14]
    end else if (ts_wr_in && ts_en_in) begin
      table_seg_out <= wr_data_in;
    end
  end

  // Same gating for the data segment. [RL16] [RL23]
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      data_seg_out <= `PSRM_SEG_RST; // [RL24]
    end else if (ds_wr_in && ds_en_in) begin
      data_seg_out <= wr_data_in;
    end
  end
endmodule

// file: rtl/psrm_top.sv
/*
 * Register resources of the core: accumulator, status word, local base,
 * stack pointer, banked pointer sets and local registers in internal RAM,
 * and the segment registers. Assumes the instruction decoder issues at
 * most one register request per cycle and reads the answer a cycle later.
 */
`timescale 1ns/100ps
`include "psrm_params.svh"

// Functional notes
// RL1: Eight pointer sets of four 16-bit registers.
// RL2: Sets at 0200H-023FH, chosen by status bits.
// RL3: Sets are eight bytes; only selected set used.
// RL4: Unused pointer area is plain RAM.
// RL5: Low byte even address, high byte odd.
// RL6: Local base picks eight-byte window; 3-bit byte.
// RL7: 2-bit field picks one of four words.
// RL8: Segment registers keep bits 3-0; upper read zero.
// RL9: Code segment only changes on far flow.
// RL10: Offsets and counter wrap, segments untouched.
// RL11: Code segment clears on reset.
// RL12: Expanded interrupt saves and restores segment too.
// RL13: Table segment writable only when enabled.
// RL14: Table segment clears on reset.
// RL15: Table fetches use the table segment.
// RL16: Data segment writable only when enabled.
// RL17: Software writes zeros to segment bits 7-4.
// RL18: Data and program spaces stay separate.
// RL19: Word uses whole accumulator, byte its low.
// RL20: Status word as word, bytes or carry.
// RL21: Byte pointer mode reaches low byte.
// RL22: Bank value n maps to 0200H plus 8n.
// RL23: Locked segment writes leave value unchanged.
// RL24: Data segment clears on reset.
module psrm_top (
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  input  wire psrm_pkg::psrm_req_t   req_in,
  output logic      [15:0]           rdata_out,
  output logic                       rvalid_out,
  input  wire psrm_pkg::psrm_flow_t  flow_in,
  input  wire logic                  pc_inc_in,
  input  wire logic [2:0]            pc_step_in,
  input  wire logic                  expanded_in,
  input  wire logic [15:0]           table_offset_in,
  output logic      [19:0]           table_addr_out,
  input  wire logic [15:0]           data_offset_in,
  output logic      [19:0]           data_addr_out,
  output logic      [3:0]            code_segment_out,
  output logic      [15:0]           pc_out,
  output psrm_pkg::psrm_frame_t      frame_out,
  output logic      [15:0]           acc_out,
  output logic      [15:0]           status_word_out
);
  import psrm_pkg::*;

  logic [15:0] accumulator;
  logic [15:0] status_word;
  logic [15:0] local_base;
  logic [15:0] system_stack_ptr;
  logic [7:0]  memory_segment_control;
  logic [3:0]  table_segment_select;
  logic [3:0]  data_segment_select;
  logic [10:0] ram_idx;
  logic        ram_hit;
  logic        ram_word;
  logic [15:0] ram_rdata;
  logic [15:0] ram_off;
  logic [15:0] next_rdata;
  logic        sfr_wr;
  logic        ctrl_wr;
  logic [7:0]  sfr_addr;

  assign sfr_addr = req_in.addr[7:0];
  assign sfr_wr   = req_in.valid && req_in.write && (req_in.op == PSRM_OP_SFR);
  assign ctrl_wr  = req_in.valid && req_in.write && (req_in.op == PSRM_OP_CTRL);
  assign ram_off  = req_in.addr - `PSRM_RAM_BASE;

  // Every RAM-resident register resolves to one byte index from 0200H.
  always_comb begin
    ram_hit  = 1'b0;
    ram_idx  = 11'h000;
    ram_word = req_in.word;
    if (req_in.op == PSRM_OP_PTR) begin
      ram_hit = 1'b1;
      ram_idx = {5'h00, status_word[2:0], req_in.sel[1:0], 1'b0}; // [RL1] [RL2] [RL3] [RL22] [RL21]
    end else if (req_in.op == PSRM_OP_LOCB) begin
      ram_hit  = 1'b1;
      ram_word = 1'b0;
      ram_idx  = {local_base[7:0], req_in.sel}; // [RL6]
    end else if (req_in.op == PSRM_OP_LOCW) begin
      ram_hit  = 1'b1;
      ram_word = 1'b1;
      ram_idx  = {local_base[7:0], req_in.sel[1:0], 1'b0}; // [RL7]
    end else if (req_in.op == PSRM_OP_RAM) begin
      // Plain RAM access, pointer area included, no side effects. [RL4] [RL18]
      ram_hit = (req_in.addr >= `PSRM_RAM_BASE) && (req_in.addr <= `PSRM_RAM_LAST);
      ram_idx = ram_off[10:0];
    end
  end

  psrm_ram u_ram (
    .clk_in    (clk_in),
    .idx_in    (ram_idx),
    .word_in   (ram_word),
    .we_in     (req_in.valid && req_in.write && ram_hit),
    .wdata_in  (req_in.wdata),
    .rdata_out (ram_rdata)
  );

  psrm_seg u_seg (
    .clk_in           (clk_in),
    .nrst_in          (nrst_in),
    .flow_in          (flow_in),
    .pc_inc_in        (pc_inc_in),
    .pc_step_in       (pc_step_in),
    .expanded_in      (expanded_in),
    .ts_wr_in         (sfr_wr && (sfr_addr == `PSRM_SFR_TSR)),
    .ds_wr_in         (sfr_wr && (sfr_addr == `PSRM_SFR_DSR)),
    .wr_data_in       (req_in.wdata[3:0]), // [RL17]
    .ts_en_in         (memory_segment_control[`PSRM_TS_EN_BIT]),
    .ds_en_in         (memory_segment_control[`PSRM_DS_EN_BIT]),
    .code_segment_out (code_segment_out),
    .pc_out           (pc_out),
    .table_seg_out    (table_segment_select),
    .data_seg_out     (data_segment_select),
    .frame_out        (frame_out)
  );

  // Byte writes touch only the low half of the accumulator. [RL19]
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      accumulator <= 16'h0000;
    end else if (req_in.valid && req_in.write && req_in.op == PSRM_OP_ACC) begin
      if (req_in.word) begin
        accumulator <= req_in.wdata;
      end else begin
        accumulator[7:0] <= req_in.wdata[7:0];
      end
    end
  end

  // Status word by word, high byte, low byte, carry bit, or SFR byte. [RL20]
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      status_word <= `PSRM_PSW_RST;
    end else if (ctrl_wr && req_in.sel == 3'h0) begin
      status_word <= req_in.wdata;
    end else if (ctrl_wr && req_in.sel == 3'h1) begin
      status_word[15:8] <= req_in.wdata[7:0];
    end else if (ctrl_wr && req_in.sel == 3'h2) begin
      status_word[7:0] <= req_in.wdata[7:0];
    end else if (ctrl_wr && req_in.sel == 3'h3) begin
      status_word[`PSRM_CY_BIT] <= req_in.wdata[0];
    end else if (sfr_wr && sfr_addr == `PSRM_SFR_STATUS_WORD_LOW) begin
      status_word[7:0] <= req_in.wdata[7:0];
    end else if (sfr_wr && sfr_addr == `PSRM_SFR_STATUS_WORD_HIGH) begin
      status_word[15:8] <= req_in.wdata[7:0];
    end
  end

  // Local base and stack pointer, by control word or SFR byte.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      local_base       <= `PSRM_LRB_RST;
      system_stack_ptr <= `PSRM_SSP_RST;
    end else if (ctrl_wr && req_in.sel == 3'h4) begin
      system_stack_ptr <= req_in.wdata;
    end else if (ctrl_wr && req_in.sel == 3'h5) begin
      local_base <= req_in.wdata;
    end else if (sfr_wr && sfr_addr == `PSRM_SFR_LOCAL_BASE_LOW) begin
      local_base[7:0] <= req_in.wdata[7:0];
    end else if (sfr_wr && sfr_addr == `PSRM_SFR_LRBH) begin
      local_base[15:8] <= req_in.wdata[7:0];
    end else if (sfr_wr && sfr_addr == `PSRM_SFR_SSPL) begin
      system_stack_ptr[7:0] <= req_in.wdata[7:0];
    end else if (sfr_wr && sfr_addr == `PSRM_SFR_SSPH) begin
      system_stack_ptr[15:8] <= req_in.wdata[7:0];
    end
  end

  // Only the two enable bits exist; the rest read zero.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      memory_segment_control <= 8'h00;
    end else if (sfr_wr && sfr_addr == `PSRM_SFR_MSC) begin
      memory_segment_control <= req_in.wdata[7:0] & `PSRM_MSC_MASK;
    end
  end

  // Answer selection; the code segment has no SFR slot at all. [RL9]
  always_comb begin
    next_rdata = 16'h0000;
    if (ram_hit) begin
      next_rdata = ram_rdata;
    end else if (req_in.op == PSRM_OP_ACC) begin
      next_rdata = req_in.word ? accumulator : {8'h00, accumulator[7:0]};
    end else if (req_in.op == PSRM_OP_CTRL) begin
      case (req_in.sel)
        3'h0: next_rdata = status_word;
        3'h1: next_rdata = {8'h00, status_word[15:8]};
        3'h2: next_rdata = {8'h00, status_word[7:0]};
        3'h3: next_rdata = {15'h0000, status_word[`PSRM_CY_BIT]};
        3'h4: next_rdata = system_stack_ptr;
        3'h5: next_rdata = local_base;
        default: next_rdata = 16'h0000;
      endcase
    end else if (req_in.op == PSRM_OP_SFR) begin
      if (sfr_addr == `PSRM_SFR_TSR) begin
        next_rdata = {12'h000, table_segment_select}; // [RL8]
      end else if (sfr_addr == `PSRM_SFR_DSR) begin
        next_rdata = {12'h000, data_segment_select}; // [RL8]
      end else if (sfr_addr == `PSRM_SFR_MSC) begin
        next_rdata = {8'h00, memory_segment_control};
      end else if (sfr_addr == `PSRM_SFR_LOCAL_BASE_LOW) begin
        next_rdata = {8'h00, local_base[7:0]};
      end else if (sfr_addr == `PSRM_SFR_LRBH) begin
        next_rdata = {8'h00, local_base[15:8]};
      end else if (sfr_addr == `PSRM_SFR_STATUS_WORD_LOW) begin
        next_rdata = {8'h00, status_word[7:0]};
      end else if (sfr_addr == `PSRM_SFR_STATUS_WORD_HIGH) begin
        next_rdata = {8'h00, status_word[15:8]};
      end else if (sfr_addr == `PSRM_SFR_SSPL) begin
        next_rdata = {8'h00, system_stack_ptr[7:0]};
      end else if (sfr_addr == `PSRM_SFR_SSPH) begin
        next_rdata = {8'h00, system_stack_ptr[15:8]};
      end
    end
  end

  // Answers come one cycle after the request, for reads and writes alike.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_out  <= 16'h0000;
      rvalid_out <= 1'b0;
    end else begin
      rdata_out  <= next_rdata;
      rvalid_out <= req_in.valid;
    end
  end

  // Table and data addresses carry the segment above a 16-bit offset. [RL15] [RL10]
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      table_addr_out <= 20'h00000;
      data_addr_out  <= 20'h00000;
    end else begin
      table_addr_out <= {table_segment_select, table_offset_in};
      data_addr_out  <= {data_segment_select, data_offset_in};
    end
  end

  assign acc_out         = accumulator;
  assign status_word_out = status_word;

  // Checks on the register behaviour.
  sequence s_int_entry;
    flow_in.op == PSRM_FL_IENT && expanded_in;
  endsequence

  sequence s_frame_out(logic [3:0] seg, logic [15:0] pc);
    frame_out.valid && frame_out.seg == seg && frame_out.pc == pc;
  endsequence

  property p_int_frame;
    @(posedge clk_in) disable iff (!nrst_in)
    s_int_entry |=> s_frame_out($past(code_segment_out), $past(pc_out));
  endproperty
  a_int_frame: assert property (p_int_frame) else $error("frame not pushed"); // [RL12]

  property p_ptr_map;
    @(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.op == PSRM_OP_PTR |->
      ram_idx[10:6] == 5'h00 && ram_idx[5:3] == status_word[2:0] && !ram_idx[0];
  endproperty
  a_ptr_map: assert property (p_ptr_map) else $error("pointer set decode wrong"); // [RL22]

  property p_loc_map;
    @(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.op == PSRM_OP_LOCW |->
      ram_idx[10:3] == local_base[7:0] && ram_word;
  endproperty
  a_loc_map: assert property (p_loc_map) else $error("local word decode wrong"); // [RL7]

  property p_ts_locked;
    @(posedge clk_in) disable iff (!nrst_in)
    sfr_wr && sfr_addr == `PSRM_SFR_TSR && !memory_segment_control[`PSRM_TS_EN_BIT]
      |=> $stable(table_segment_select);
  endproperty
  a_ts_locked: assert property (p_ts_locked) else $error("table seg written"); // [RL13]

  property p_ds_locked;
    @(posedge clk_in) disable iff (!nrst_in)
    sfr_wr && sfr_addr == `PSRM_SFR_DSR && !memory_segment_control[`PSRM_DS_EN_BIT]
      |=> $stable(data_segment_select);
  endproperty
  a_ds_locked: assert property (p_ds_locked) else $error("data seg written"); // [RL16]

  property p_seg_upper_zero;
    @(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.op == PSRM_OP_SFR &&
      (sfr_addr == `PSRM_SFR_TSR || sfr_addr == `PSRM_SFR_DSR)
      |=> rvalid_out && rdata_out[15:4] == 12'h000;
  endproperty
  a_seg_upper_zero: assert property (p_seg_upper_zero) else $error("seg upper set"); // [RL8]

  property p_reset_seg;
    @(posedge clk_in)
    $rose(nrst_in) |-> code_segment_out == 4'h0 && table_segment_select == 4'h0 &&
      data_segment_select == 4'h0;
  endproperty
  a_reset_seg: assert property (p_reset_seg) else $error("segment not reset"); // [RL11]

  property p_pc_wrap;
    @(posedge clk_in) disable iff (!nrst_in)
    pc_inc_in && flow_in.op == PSRM_FL_NONE |=>
      pc_out == $past(pc_out) + {13'h0000, $past(pc_step_in)} && $stable(code_segment_out);
  endproperty
  a_pc_wrap: assert property (p_pc_wrap) else $error("pc wrap wrong"); // [RL10]

  property p_cs_no_sfr;
    @(posedge clk_in) disable iff (!nrst_in)
    flow_in.op == PSRM_FL_NONE |=> $stable(code_segment_out);
  endproperty
  a_cs_no_sfr: assert property (p_cs_no_sfr) else $error("code seg moved"); // [RL9]

  property p_acc_byte;
    @(posedge clk_in) disable iff (!nrst_in)
    req_in.valid && req_in.write && req_in.op == PSRM_OP_ACC && !req_in.word
      |=> $stable(accumulator[15:8]) && accumulator[7:0] == $past(req_in.wdata[7:0]);
  endproperty
  a_acc_byte: assert property (p_acc_byte) else $error("acc byte write wrong"); // [RL19]
endmodule

// file: verif/psrm_bench.sv
/* Self-checking bench for the pointer and segment register block.
   Assumes the decoder model drives every core input but clock and reset. */
`timescale 1ns/100ps
`include "psrm_params.svh"
module psrm_bench;
  import psrm_pkg::*;
  logic        clk_in;
  logic        nrst_in;
  psrm_req_t   req;
  psrm_flow_t  flow;
  psrm_frame_t frame;
  logic        pc_inc, expanded, rvalid;
  logic [2:0]  pc_step, b;
  logic [15:0] toff, doff, rdata, pc, acc, sword, a;
  logic [19:0] taddr, daddr;
  logic [3:0]  cseg;
  int          err_total;
  int          n_compared;
  localparam logic [15:0] TS_A = {8'h00, `PSRM_SFR_TSR};
  localparam logic [15:0] DS_A = {8'h00, `PSRM_SFR_DSR};
  localparam logic [15:0] MS_A = {8'h00, `PSRM_SFR_MSC};
  psrm_flow_op_t ops[3] = '{PSRM_FL_FCALL, PSRM_FL_VCALL, PSRM_FL_FRET};

  psrm_dec_model dec_u (.clk_in(clk_in), .req_out(req), .flow_out(flow),
    .pc_inc_out(pc_inc), .pc_step_out(pc_step), .expanded_out(expanded),
    .table_offset_out(toff), .data_offset_out(doff));
  psrm_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .flow_in(flow), .pc_inc_in(pc_inc), .pc_step_in(pc_step),
    .expanded_in(expanded), .table_offset_in(toff), .table_addr_out(taddr),
    .data_offset_in(doff), .data_addr_out(daddr), .code_segment_out(cseg),
    .pc_out(pc), .frame_out(frame), .acc_out(acc), .status_word_out(sword));

  // Core clock at 25 MHz.
  initial clk_in = 1'b0;
  always #20 clk_in = ~clk_in;

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t data %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_addr(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t address %h, expected %h", $time, got, exp);
    end
  endtask
  // Every request, write or read, is answered exactly one cycle later.
  task automatic wr(input psrm_op_t op, input logic wd, input logic [2:0] sel,
                    input logic [15:0] ad, input logic [15:0] d);
    dec_u.reg_op(op, 1'b1, wd, sel, ad, d);
    #1;
    chk_data({15'h0000, rvalid}, 16'h0001);
  endtask
  task automatic rd(input psrm_op_t op, input logic wd, input logic [2:0] sel,
                    input logic [15:0] ad, input logic [15:0] exp);
    dec_u.reg_op(op, 1'b0, wd, sel, ad, 16'h0000);
    #1;
    chk_data({15'h0000, rvalid}, 16'h0001);
    chk_data(rdata, exp);
  endtask

  // A hang is cut short well beyond the roughly two hundred cycles the tests need.
  initial begin
    #160000;
    err_total++;
    give_verdict();
  end

  initial begin
    nrst_in = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1;
    chk_data(sword, 16'h0000);
    chk_data({12'h000, cseg}, 16'h0000);
    rd(PSRM_OP_SFR, 1'b0, 3'h0, TS_A, 16'h0000);
    rd(PSRM_OP_SFR, 1'b0, 3'h0, DS_A, 16'h0000);
    rd(PSRM_OP_CTRL, 1'b1, 3'h4, 16'h0000, 16'hFFFF);
    // Segment writes are dropped while their own enable bit is clear and land once it is set.
    wr(PSRM_OP_SFR, 1'b0, 3'h0, TS_A, 16'h0005);
    rd(PSRM_OP_SFR, 1'b0, 3'h0, TS_A, 16'h0000);
    wr(PSRM_OP_SFR, 1'b0, 3'h0, MS_A, 16'h0002);
    wr(PSRM_OP_SFR, 1'b0, 3'h0, TS_A, 16'h00F5);
    rd(PSRM_OP_SFR, 1'b0, 3'h0, TS_A, 16'h0005);
    wr(PSRM_OP_SFR, 1'b0, 3'h0, DS_A, 16'h000A);
    rd(PSRM_OP_SFR, 1'b0, 3'h0, DS_A, 16'h0000);
    wr(PSRM_OP_SFR, 1'b0, 3'h0, MS_A, 16'h0001);
    wr(PSRM_OP_SFR, 1'b0, 3'h0, DS_A, 16'h000A);
    wr(PSRM_OP_SFR, 1'b0, 3'h0, TS_A, 16'h0003);
    rd(PSRM_OP_SFR, 1'b0, 3'h0, DS_A, 16'h000A);
    rd(PSRM_OP_SFR, 1'b0, 3'h0, TS_A, 16'h0005);
    rd(PSRM_OP_SFR, 1'b0, 3'h0, MS_A, 16'h0001);
    dec_u.set_offsets(16'h1234, 16'hABCD);
    #1;
    chk_addr(taddr, 20'h51234);
    chk_addr(daddr, 20'hAABCD);
    // Each bank value reaches its own eight bytes; pairs are low byte first.
    for (int n = 0; n < 8; n++) begin
      b = 3'(n);
      a = 16'h0200 + {10'h000, b, 3'h0} + {13'h0000, b[1:0], 1'b0};
      wr(PSRM_OP_CTRL, 1'b0, 3'h2, 16'h0000, {13'h0000, b});
      wr(PSRM_OP_PTR, 1'b1, {1'b0, b[1:0]}, 16'h0000, {5'h18, b, 8'h5A});
      rd(PSRM_OP_RAM, 1'b1, 3'h0, a, {5'h18, b, 8'h5A});
      rd(PSRM_OP_RAM, 1'b0, 3'h0, a + 16'h0001, {8'h00, 5'h18, b});
      rd(PSRM_OP_PTR, 1'b0, {1'b0, b[1:0]}, 16'h0000, 16'h005A);
    end
    wr(PSRM_OP_CTRL, 1'b0, 3'h2, 16'h0000, 16'h0000);
    rd(PSRM_OP_PTR, 1'b1, 3'h0, 16'h0000, 16'hC05A);
    wr(PSRM_OP_RAM, 1'b1, 3'h0, 16'h0206, 16'hBEEF);
    rd(PSRM_OP_PTR, 1'b1, 3'h3, 16'h0000, 16'hBEEF);
    wr(PSRM_OP_RAM, 1'b1, 3'h0, 16'h0A00, 16'h1111);
    rd(PSRM_OP_RAM, 1'b1, 3'h0, 16'h0A00, 16'h0000);
    // Local window 11h starts at 0288h.
    wr(PSRM_OP_CTRL, 1'b1, 3'h5, 16'h0000, 16'h0011);
    wr(PSRM_OP_LOCB, 1'b0, 3'h3, 16'h0000, 16'h0077);
    rd(PSRM_OP_RAM, 1'b0, 3'h0, 16'h028B, 16'h0077);
    wr(PSRM_OP_LOCW, 1'b1, 3'h2, 16'h0000, 16'h1357);
    rd(PSRM_OP_RAM, 1'b1, 3'h0, 16'h028C, 16'h1357);
    wr(PSRM_OP_ACC, 1'b1, 3'h0, 16'h0000, 16'h1234);
    rd(PSRM_OP_ACC, 1'b0, 3'h0, 16'h0000, 16'h0034);
    wr(PSRM_OP_ACC, 1'b0, 3'h0, 16'h0000, 16'h00CD);
    chk_data(acc, 16'h12CD);
    wr(PSRM_OP_CTRL, 1'b1, 3'h0, 16'h0000, 16'h8421);
    rd(PSRM_OP_CTRL, 1'b0, 3'h1, 16'h0000, 16'h0084);
    rd(PSRM_OP_CTRL, 1'b0, 3'h2, 16'h0000, 16'h0021);
    rd(PSRM_OP_CTRL, 1'b0, 3'h3, 16'h0000, 16'h0001);
    wr(PSRM_OP_CTRL, 1'b0, 3'h3, 16'h0000, 16'h0000);
    chk_data(sword, 16'h0421);
    wr(PSRM_OP_SFR, 1'b0, 3'h0, {8'h00, `PSRM_SFR_STATUS_WORD_HIGH}, 16'h0066);
    rd(PSRM_OP_CTRL, 1'b1, 3'h0, 16'h0000, 16'h6621);
    // Far flow, counter wrap, and the expanded interrupt frame.
    dec_u.flow_op(PSRM_FL_FJMP, 4'h3, 16'hFFFE, 1'b0);
    #1;
    chk_addr({cseg, pc}, 20'h3FFFE);
    dec_u.step_pc(3'h4);
    #1;
    chk_addr({cseg, pc}, 20'h30002);
    dec_u.flow_op(PSRM_FL_IENT, 4'h2, 16'h0100, 1'b1);
    #1;
    chk_addr({frame.seg, frame.pc}, 20'h30002);
    chk_data({15'h0000, frame.valid}, 16'h0001);
    chk_addr({cseg, pc}, 20'h20100);
    dec_u.flow_op(PSRM_FL_IRET, 4'h3, 16'h0002, 1'b1);
    #1;
    chk_addr({cseg, pc}, 20'h30002);
    dec_u.flow_op(PSRM_FL_IRET, 4'h5, 16'h0040, 1'b0);
    #1;
    chk_addr({cseg, pc}, 20'h30040);
    for (int k = 0; k < 3; k++) begin
      dec_u.flow_op(ops[k], 4'(k + 7), 16'h0010, 1'b0);
      #1;
      chk_addr({cseg, pc}, {4'(k + 7), 16'h0010});
    end
    give_verdict();
  end
endmodule

// file: verif/psrm_dec_model.sv
/* Behavioural decoder that issues register requests, flow events, program
   counter steps and table or data offsets to the register block.
   Assumes a free-running core clock; the bench calls its tasks. */
`timescale 1ns/100ps
`include "psrm_params.svh"
module psrm_dec_model (
  input  wire logic             clk_in,
  output psrm_pkg::psrm_req_t   req_out,
  output psrm_pkg::psrm_flow_t  flow_out,
  output logic                  pc_inc_out,
  output logic      [2:0]       pc_step_out,
  output logic                  expanded_out,
  output logic      [15:0]      table_offset_out,
  output logic      [15:0]      data_offset_out
);
  import psrm_pkg::*;
  // Idle at time zero so the core never sees an unknown request.
  initial begin
    req_out = '0;
    flow_out = '0;
    pc_inc_out = 1'b0;
    pc_step_out = 3'h0;
    expanded_out = 1'b0;
    table_offset_out = 16'h0000;
    data_offset_out = 16'h0000;
  end
  // One request, held for the edge that takes it; fields then scramble.
  task automatic reg_op(input psrm_op_t op, input logic wr, input logic wd,
                        input logic [2:0] sel, input logic [15:0] addr,
                        input logic [15:0] wdata);
    logic [15:0] d;
    d = wdata;
    if (op == PSRM_OP_SFR && addr[7:0] inside {`PSRM_SFR_TSR, `PSRM_SFR_DSR})
      d[7:4] = 4'h0;
    @(posedge clk_in);
    req_out <= '{valid: 1'b1, op: op, write: wr, word: wd, sel: sel, addr: addr, wdata: d};
    @(posedge clk_in);
    req_out <= {1'b0, ~req_out[$bits(psrm_req_t)-2:0]};
  endtask
  // One flow event lasting a single cycle, as the core expects.
  task automatic flow_op(input psrm_flow_op_t op, input logic [3:0] seg,
                         input logic [15:0] tgt, input logic ex);
    @(posedge clk_in);
    flow_out <= '{op: op, seg: seg, target: tgt};
    expanded_out <= ex;
    @(posedge clk_in);
    flow_out <= '{op: PSRM_FL_NONE, seg: ~seg, target: ~tgt};
  endtask
  // Advance the program counter once by the given byte count.
  task automatic step_pc(input logic [2:0] step);
    @(posedge clk_in);
    pc_inc_out <= 1'b1;
    pc_step_out <= step;
    @(posedge clk_in);
    pc_inc_out <= 1'b0;
  endtask
  // Offsets settle one edge before the registered address is read.
  task automatic set_offsets(input logic [15:0] t, input logic [15:0] d);
    @(posedge clk_in);
    table_offset_out <= t;
    data_offset_out <= d;
    @(posedge clk_in);
  endtask
endmodule
